// ### src/wbgc_consts.svh
`ifndef WBGC_CONSTS_SVH
`define WBGC_CONSTS_SVH

// ==========================================================================
// Register addresses
`define WBGC_ADDR_CTRL      32'hf0f0080c
`define WBGC_ADDR_INQ       32'hf10080c0
`define WBGC_ADDR_PAIR_A    32'hf10080c4
`define WBGC_ADDR_PAIR_B    32'hf10080c8

// ==========================================================================
// Field positions
`define WBGC_BIT_PRESENT    0
`define WBGC_BIT_ABS        1
`define WBGC_BIT_ONEPUSH    5
`define WBGC_BIT_ONOFF      6
`define WBGC_BIT_AUTO       7
`define WBGC_LO_LSB         8
`define WBGC_LO_MSB         19
`define WBGC_HI_LSB         20
`define WBGC_HI_MSB         31

// ==========================================================================
// Reset values
`define WBGC_ON_RST         1'b1
`define WBGC_GAIN_RST       12'h000

// ==========================================================================
// Gain arithmetic and run lengths
`define WBGC_GAIN_MAX       9'h1ff
`define WBGC_UNITY          10'h100
`define WBGC_Q_TOP          10'h2ff
`define WBGC_GAIN_SHIFT     8
`define WBGC_ONEPUSH_FRAMES 4'h8
`define WBGC_AUTO_FRAMES    4'h1
`define WBGC_DIV_MSB        4'h9

// ==========================================================================
// Colour slot of a pixel
`define WBGC_CH_RED         2'h0
`define WBGC_CH_GREEN       2'h1
`define WBGC_CH_BLUE        2'h2

`endif

// ### src/wbgc_pkg.sv
package wbgc_pkg;

  // ========================================================================
  // Types
  typedef logic [11:0] wbgc_gain_t;

  typedef enum logic [2:0] {
    WBGC_ST_IDLE  = 3'h0,
    WBGC_ST_WAIT  = 3'h1,
    WBGC_ST_ACCUM = 3'h3,
    WBGC_ST_DIV_R = 3'h2,
    WBGC_ST_DIV_B = 3'h6,
    WBGC_ST_LOAD  = 3'h7
  } wbgc_state_e;

endpackage : wbgc_pkg

// ### src/wbgc_pair_buf.sv
`timescale 1ns/100ps

module wbgc_pair_buf #(
  parameter int W = 8
) (
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  if (W < 1)
  begin : g_bad_w
    $error("wbgc_pair_buf: W must be positive");
  end

  logic         head_v_q;
  logic         head_v_d;
  logic         tail_v_q;
  logic         tail_v_d;
  logic [W-1:0] head_q;
  logic [W-1:0] head_d;
  logic [W-1:0] tail_q;
  logic [W-1:0] tail_d;
  logic         rdy_q;
  logic         rdy_d;
  logic         push;
  logic         pop;

  // ========================================================================
  // Two slots; head drives the output, ready drops while both are full
  always_comb
  begin
    push     = in_valid_i && rdy_q;
    pop      = head_v_q && out_ready_i;
    head_v_d = head_v_q;
    tail_v_d = tail_v_q;
    head_d   = head_q;
    tail_d   = tail_q;
    if (pop)
    begin
      if (tail_v_q)
      begin
        head_d   = tail_q;
        tail_v_d = 1'b0;
      end
      else
      begin
        head_v_d = 1'b0;
      end
    end
    if (push)
    begin
      if (!head_v_d)
      begin
        head_v_d = 1'b1;
        head_d   = in_data_i;
      end
      else
      begin
        tail_v_d = 1'b1;
        tail_d   = in_data_i;
      end
    end
    rdy_d = !tail_v_d;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
      head_q   <= '0;
      tail_q   <= '0;
      rdy_q    <= 1'b1;
    end
    else
    begin
      head_v_q <= head_v_d;
      tail_v_q <= tail_v_d;
      head_q   <= head_d;
      tail_q   <= tail_d;
      rdy_q    <= rdy_d;
    end
  end

  assign in_ready_o  = rdy_q;
  assign out_valid_o = head_v_q;
  assign out_data_o  = head_q;

  a_hold_stalled: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    head_v_q && !out_ready_i |=> head_v_q && $stable(head_q))
    else $error("buffer output changed while stalled");

endmodule : wbgc_pair_buf

// ### src/wbgc_core.sv
`timescale 1ns/100ps
`include "wbgc_consts.svh"

module wbgc_core #(
  parameter int PIX_W           = 12,
  parameter int ACC_W           = 40,
  parameter bit FEATURE_PRESENT = 1'b1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic [31:0]      reg_addr_i,
  input  wire logic             reg_wr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_rd_i,
  output logic [31:0]           reg_rdata_o,
  output logic                  reg_rvalid_o,
  input  wire logic [11:0]      abs_ub_gain_i,
  input  wire logic [11:0]      abs_vr_gain_i,
  input  wire logic             complement_mode_i,
  input  wire logic [PIX_W-1:0] pix_offset_i,
  input  wire logic             pix_valid_i,
  output logic                  pix_ready_o,
  input  wire logic             pix_sof_i,
  input  wire logic [1:0]       pix_chan_i,
  input  wire logic [PIX_W-1:0] pix_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic                  out_sof_o,
  output logic [1:0]            out_chan_o,
  output logic [PIX_W-1:0]      out_data_o
);

  if (PIX_W < 8 || PIX_W > 16)
  begin : g_bad_pix_w
    $error("wbgc_core: PIX_W must lie in 8..16");
  end
  if (ACC_W < PIX_W + 19 || ACC_W > 48)
  begin : g_bad_acc_w
    $error("wbgc_core: ACC_W must lie in PIX_W+19..48");
  end

  localparam int RW = ACC_W + 10;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // ========================================================================
  // Gain helpers
  function automatic logic [8:0] wbgc_clamp(input wbgc_pkg::wbgc_gain_t g);
    return (g > 12'(`WBGC_GAIN_MAX)) ? `WBGC_GAIN_MAX : g[8:0];
  endfunction : wbgc_clamp

  function automatic wbgc_pkg::wbgc_gain_t wbgc_q2gain(input logic [9:0] q,
                                                       input logic       sat);
    if (sat || q >= `WBGC_Q_TOP)
      return 12'(`WBGC_GAIN_MAX);
    else if (q < `WBGC_UNITY)
      return 12'h000;
    else
      return {2'h0, q - `WBGC_UNITY};
  endfunction : wbgc_q2gain

  // ========================================================================
  // State
  wbgc_pkg::wbgc_state_e st_q, st_d;
  logic                  abs_q, abs_d, on_q, on_d, auto_q, auto_d, busy_q, busy_d;
  logic                  pa_on_q, pa_on_d, pa_auto_q, pa_auto_d;
  wbgc_pkg::wbgc_gain_t  ub_q, ub_d, vr_q, vr_d, gain_r_q, gain_r_d, gain_b_q, gain_b_d;
  wbgc_pkg::wbgc_gain_t  stg_q [4];
  wbgc_pkg::wbgc_gain_t  stg_d [4];
  wbgc_pkg::wbgc_gain_t  act_q [4];
  wbgc_pkg::wbgc_gain_t  act_d [4];
  logic [31:0]           rdata_q, rdata_d;
  logic                  rvalid_q;
  logic [ACC_W-1:0]      acc_r_q, acc_r_d, acc_g_q, acc_g_d, acc_b_q, acc_b_d;
  logic [3:0]            fcnt_q, fcnt_d, bit_q, bit_d;
  logic [RW-1:0]         rem_q, rem_d;
  logic [9:0]            quo_q, quo_d;
  logic                  sat_q, sat_d;

  logic                  take, ctrl_wr, auto_run, clr, acc_en, hit;
  logic [3:0]            frames;
  logic [ACC_W-1:0]      dvs, pix_ext;
  logic [RW-1:0]         trial, numer;
  logic [9:0]            quo_new;
  wbgc_pkg::wbgc_gain_t  raw_gain, result;
  logic                  gain_en;
  logic [8:0]            gain9;
  logic [PIX_W:0]        sum;
  logic [PIX_W-1:0]      sum_sat;
  logic [PIX_W+9:0]      prod;
  logic [PIX_W+1:0]      scaled;
  logic [PIX_W-1:0]      pix_out;

  assign take     = pix_valid_i && pix_ready_o;
  assign ctrl_wr  = reg_wr_i && (reg_addr_i == `WBGC_ADDR_CTRL);
  assign auto_run = auto_q && on_q && !complement_mode_i;

  // ========================================================================
  // Register file
  always_comb
  begin
    abs_d     = abs_q;
    on_d      = on_q;
    auto_d    = auto_q;
    busy_d    = busy_q;
    ub_d      = ub_q;
    vr_d      = vr_q;
    pa_on_d   = pa_on_q;
    pa_auto_d = pa_auto_q;
    stg_d     = stg_q;
    rdata_d   = 32'h0000_0000;
    if (ctrl_wr)
    begin
      abs_d  = reg_wdata_i[`WBGC_BIT_ABS];
      on_d   = reg_wdata_i[`WBGC_BIT_ONOFF];
      auto_d = reg_wdata_i[`WBGC_BIT_AUTO];
      if (!reg_wdata_i[`WBGC_BIT_AUTO])
      begin
        ub_d = reg_wdata_i[`WBGC_LO_MSB:`WBGC_LO_LSB];
        vr_d = reg_wdata_i[`WBGC_HI_MSB:`WBGC_HI_LSB];
      end
      if (reg_wdata_i[`WBGC_BIT_ONEPUSH] && !reg_wdata_i[`WBGC_BIT_AUTO] && !busy_q
          && !complement_mode_i && FEATURE_PRESENT)
        busy_d = 1'b1;
    end
    if (reg_wr_i && reg_addr_i == `WBGC_ADDR_PAIR_A)
    begin
      pa_on_d   = reg_wdata_i[`WBGC_BIT_ONOFF];
      pa_auto_d = reg_wdata_i[`WBGC_BIT_AUTO];
      stg_d[1]  = reg_wdata_i[`WBGC_LO_MSB:`WBGC_LO_LSB];
      stg_d[0]  = reg_wdata_i[`WBGC_HI_MSB:`WBGC_HI_LSB];
    end
    if (reg_wr_i && reg_addr_i == `WBGC_ADDR_PAIR_B)
    begin
      stg_d[3] = reg_wdata_i[`WBGC_LO_MSB:`WBGC_LO_LSB];
      stg_d[2] = reg_wdata_i[`WBGC_HI_MSB:`WBGC_HI_LSB];
    end
    if (st_q == wbgc_pkg::WBGC_ST_LOAD)
    begin
      ub_d   = gain_b_q;
      vr_d   = gain_r_q;
      busy_d = busy_d && !busy_q;
    end
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `WBGC_ADDR_CTRL:
        begin
          rdata_d[`WBGC_BIT_PRESENT]            = FEATURE_PRESENT;
          rdata_d[`WBGC_BIT_ABS]                = abs_q;
          rdata_d[`WBGC_BIT_ONEPUSH]            = busy_q;
          rdata_d[`WBGC_BIT_ONOFF]              = on_q;
          rdata_d[`WBGC_BIT_AUTO]               = auto_q;
          rdata_d[`WBGC_LO_MSB:`WBGC_LO_LSB]    = ub_q;
          rdata_d[`WBGC_HI_MSB:`WBGC_HI_LSB]    = vr_q;
        end
        `WBGC_ADDR_PAIR_A:
        begin
          rdata_d[`WBGC_BIT_PRESENT]            = 1'b1;
          rdata_d[`WBGC_BIT_ONOFF]              = pa_on_q;
          rdata_d[`WBGC_BIT_AUTO]               = pa_auto_q;
          rdata_d[`WBGC_LO_MSB:`WBGC_LO_LSB]    = stg_q[1];
          rdata_d[`WBGC_HI_MSB:`WBGC_HI_LSB]    = stg_q[0];
        end
        `WBGC_ADDR_PAIR_B:
        begin
          rdata_d[`WBGC_BIT_PRESENT]            = 1'b1;
          rdata_d[`WBGC_LO_MSB:`WBGC_LO_LSB]    = stg_q[3];
          rdata_d[`WBGC_HI_MSB:`WBGC_HI_LSB]    = stg_q[2];
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // Measurement engine: accumulate, then divide green by red and blue
  always_comb
  begin
    st_d     = st_q;
    fcnt_d   = fcnt_q;
    bit_d    = bit_q;
    rem_d    = rem_q;
    quo_d    = quo_q;
    sat_d    = sat_q;
    gain_r_d = gain_r_q;
    gain_b_d = gain_b_q;
    clr      = 1'b0;
    acc_en   = 1'b0;
    frames   = busy_q ? `WBGC_ONEPUSH_FRAMES : `WBGC_AUTO_FRAMES;
    pix_ext  = ACC_W'(pix_data_i);
    numer    = {2'h0, acc_g_q, 8'h00};
    dvs      = (st_q == wbgc_pkg::WBGC_ST_DIV_B) ? acc_b_q : acc_r_q;
    trial    = {10'h000, dvs} << bit_q;
    hit      = rem_q >= trial;
    quo_new  = quo_q | (hit ? (10'h001 << bit_q) : 10'h000);
    if (bit_q == `WBGC_DIV_MSB)
      sat_d = rem_q >= {dvs, 10'h000};
    result   = wbgc_q2gain(quo_new, sat_d);
    unique case (st_q)
      wbgc_pkg::WBGC_ST_IDLE:
        if (busy_q || auto_run)
          st_d = wbgc_pkg::WBGC_ST_WAIT;
      wbgc_pkg::WBGC_ST_WAIT:
        if (take && pix_sof_i)
        begin
          st_d   = wbgc_pkg::WBGC_ST_ACCUM;
          clr    = 1'b1;
          acc_en = 1'b1;
          fcnt_d = 4'h0;
        end
      wbgc_pkg::WBGC_ST_ACCUM:
        if (take)
        begin
          if (pix_sof_i && fcnt_q == frames - 4'h1)
          begin
            st_d  = wbgc_pkg::WBGC_ST_DIV_R;
            rem_d = numer;
            quo_d = 10'h000;
            bit_d = `WBGC_DIV_MSB;
          end
          else
          begin
            acc_en = 1'b1;
            if (pix_sof_i)
              fcnt_d = fcnt_q + 4'h1;
          end
        end
      wbgc_pkg::WBGC_ST_DIV_R,
      wbgc_pkg::WBGC_ST_DIV_B:
      begin
        rem_d = hit ? rem_q - trial : rem_q;
        quo_d = quo_new;
        bit_d = bit_q - 4'h1;
        if (bit_q == 4'h0)
        begin
          rem_d = numer;
          quo_d = 10'h000;
          bit_d = `WBGC_DIV_MSB;
          if (st_q == wbgc_pkg::WBGC_ST_DIV_R)
          begin
            gain_r_d = result;
            st_d     = wbgc_pkg::WBGC_ST_DIV_B;
          end
          else
          begin
            gain_b_d = result;
            st_d     = wbgc_pkg::WBGC_ST_LOAD;
          end
        end
      end
      wbgc_pkg::WBGC_ST_LOAD:
        st_d = auto_run ? wbgc_pkg::WBGC_ST_WAIT : wbgc_pkg::WBGC_ST_IDLE;
      default: st_d = wbgc_pkg::WBGC_ST_IDLE;
    endcase
    if (st_q != wbgc_pkg::WBGC_ST_IDLE && !busy_q && !auto_run)
      st_d = wbgc_pkg::WBGC_ST_IDLE;
    acc_r_d = clr ? '0 : acc_r_q;
    acc_g_d = clr ? '0 : acc_g_q;
    acc_b_d = clr ? '0 : acc_b_q;
    if (acc_en)
    begin
      unique case (pix_chan_i)
        `WBGC_CH_RED:   acc_r_d = acc_r_d + pix_ext;
        `WBGC_CH_GREEN: acc_g_d = acc_g_d + pix_ext;
        `WBGC_CH_BLUE:  acc_b_d = acc_b_d + pix_ext;
        default:        acc_g_d = acc_g_d;
      endcase
    end
  end

  // ========================================================================
  // Pixel path: pick gain, add offset, scale, saturate
  always_comb
  begin
    act_d = (take && pix_sof_i) ? stg_q : act_q;
    if (complement_mode_i)
    begin
      raw_gain = pix_sof_i ? stg_q[pix_chan_i] : act_q[pix_chan_i];
      gain_en  = pa_on_q;
    end
    else
    begin
      gain_en = on_q;
      unique case (pix_chan_i)
        `WBGC_CH_RED:  raw_gain = abs_q ? abs_vr_gain_i : vr_q;
        `WBGC_CH_BLUE: raw_gain = abs_q ? abs_ub_gain_i : ub_q;
        default:       raw_gain = 12'h000;
      endcase
    end
    gain9   = gain_en ? wbgc_clamp(raw_gain) : 9'h000;
    sum     = {1'b0, pix_data_i} + {1'b0, pix_offset_i};
    sum_sat = sum[PIX_W] ? '1 : sum[PIX_W-1:0];
    prod    = (PIX_W+10)'(sum_sat) * (PIX_W+10)'({1'b0, gain9} + `WBGC_UNITY);
    scaled  = prod[PIX_W+9:`WBGC_GAIN_SHIFT];
    pix_out = (scaled[PIX_W+1:PIX_W] != 2'h0) ? '1 : scaled[PIX_W-1:0];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      st_q <= wbgc_pkg::WBGC_ST_IDLE;
      {abs_q, auto_q, busy_q, pa_auto_q} <= 4'h0;
      on_q <= `WBGC_ON_RST;
      pa_on_q <= `WBGC_ON_RST;
      {ub_q, vr_q, gain_r_q, gain_b_q} <= {4{`WBGC_GAIN_RST}};
      stg_q <= '{default: `WBGC_GAIN_RST};
      act_q <= '{default: `WBGC_GAIN_RST};
      {rdata_q, rvalid_q} <= 33'h0;
      {acc_r_q, acc_g_q, acc_b_q} <= '0;
      {fcnt_q, bit_q, quo_q, sat_q} <= 19'h0;
      rem_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      {abs_q, auto_q, busy_q, pa_auto_q} <= {abs_d, auto_d, busy_d, pa_auto_d};
      on_q <= on_d;
      pa_on_q <= pa_on_d;
      {ub_q, vr_q, gain_r_q, gain_b_q} <= {ub_d, vr_d, gain_r_d, gain_b_d};
      stg_q <= stg_d;
      act_q <= act_d;
      {rdata_q, rvalid_q} <= {rdata_d, reg_rd_i};
      {acc_r_q, acc_g_q, acc_b_q} <= {acc_r_d, acc_g_d, acc_b_d};
      {fcnt_q, bit_q, quo_q, sat_q} <= {fcnt_d, bit_d, quo_d, sat_d};
      rem_q <= rem_d;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  wbgc_pair_buf #(
    .W (PIX_W + 3)
  ) u_out_buf (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (pix_valid_i),
    .in_ready_o  (pix_ready_o),
    .in_data_i   ({pix_sof_i, pix_chan_i, pix_out}),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  ({out_sof_o, out_chan_o, out_data_o})
  );

  // ========================================================================
  // Checks
  a_presence_read: assert property (reg_rd_i && reg_addr_i == `WBGC_ADDR_CTRL
    |=> reg_rvalid_o && reg_rdata_o[`WBGC_BIT_PRESENT] == FEATURE_PRESENT)
    else $error("presence bit wrong");
  a_abs_select: assert property (!complement_mode_i && on_q && abs_q
    && pix_chan_i == `WBGC_CH_RED |-> gain9 == wbgc_clamp(abs_vr_gain_i))
    else $error("absolute gain not used");
  a_busy_readback: assert property (reg_rd_i && reg_addr_i == `WBGC_ADDR_CTRL
    |=> reg_rdata_o[`WBGC_BIT_ONEPUSH] == $past(busy_q))
    else $error("one-push status misread");
  a_off_bypass: assert property (!complement_mode_i && !on_q |-> gain9 == 9'h000)
    else $error("gain applied while off");
  a_auto_locks_value: assert property (ctrl_wr && reg_wdata_i[`WBGC_BIT_AUTO]
    && st_q != wbgc_pkg::WBGC_ST_LOAD |=> $stable(ub_q) && $stable(vr_q))
    else $error("value field written in auto mode");
  a_green_unity: assert property (!complement_mode_i
    && pix_chan_i == `WBGC_CH_GREEN |-> gain9 == 9'h000)
    else $error("reference channel gained");
  a_onepush_holds: assert property (st_q == wbgc_pkg::WBGC_ST_IDLE && !busy_q
    && !auto_run && !reg_wr_i |=> $stable(ub_q) && $stable(vr_q))
    else $error("gains moved after one-push");
  a_auto_rearms: assert property (st_q == wbgc_pkg::WBGC_ST_LOAD && auto_run
    |=> st_q == wbgc_pkg::WBGC_ST_WAIT)
    else $error("auto mode stopped adjusting");
  a_eight_frames: assert property (st_q == wbgc_pkg::WBGC_ST_ACCUM && busy_q && take
    && pix_sof_i |-> (fcnt_q == 4'h7) == (st_d == wbgc_pkg::WBGC_ST_DIV_R))
    else $error("one-push frame count wrong");
  a_divide_span: assert property ($rose(st_q == wbgc_pkg::WBGC_ST_DIV_R) && busy_q
    |-> ##20 st_q == wbgc_pkg::WBGC_ST_LOAD)
    else $error("division length wrong");
  a_load_result: assert property (st_q == wbgc_pkg::WBGC_ST_LOAD
    |=> ub_q == $past(gain_b_q) && vr_q == $past(gain_r_q))
    else $error("result not placed in value fields");
  a_frame_apply: assert property (take && pix_sof_i
    |=> act_q[0] == $past(stg_q[0]) && act_q[3] == $past(stg_q[3]))
    else $error("staged gains not applied at frame start");
  a_busy_clears: assert property (st_q == wbgc_pkg::WBGC_ST_LOAD && busy_q
    |=> !busy_q && ub_q == $past(gain_b_q))
    else $error("one-push status stuck");

  c_onepush_done: cover property (st_q == wbgc_pkg::WBGC_ST_LOAD && busy_q);
  c_auto_load: cover property (st_q == wbgc_pkg::WBGC_ST_LOAD && auto_run);
  c_comp_frame: cover property (take && pix_sof_i && complement_mode_i);
  c_backpressure: cover property (pix_valid_i && !pix_ready_o);

endmodule : wbgc_core

// ### tb/testbench.sv
`timescale 1ns/100ps
`include "wbgc_consts.svh"

module testbench;
  // ==========================
  // Signals
  logic        sys_clk_i, srst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, complement_mode_i;
  logic [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
  logic [11:0] abs_ub_gain_i, abs_vr_gain_i, pix_offset_i, pix_data_i, out_data_o, ub, vr;
  logic [1:0]  pix_chan_i, out_chan_o;
  logic        pix_valid_i, pix_ready_o, pix_sof_i, out_valid_o, out_ready_i, out_sof_o;
  logic        rnd_rdy, stall, feat_on, abs_on, saw_full;
  logic [11:0] stg[4], act[4];
  logic [14:0] po;
  logic [14:0] exp_q[$];
  integer      seed;
  int          errors, compares, k, i;

  // ==========================
  // Clock and design
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  wbgc_core dut_u (
    .sys_clk_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
    .reg_rvalid_o, .abs_ub_gain_i, .abs_vr_gain_i, .complement_mode_i, .pix_offset_i,
    .pix_valid_i, .pix_ready_o, .pix_sof_i, .pix_chan_i, .pix_data_i, .out_valid_o,
    .out_ready_i, .out_sof_o, .out_chan_o, .out_data_o
  );

  assign po = {out_sof_o, out_chan_o, out_data_o};

  // Sink readiness, random or stalled on demand
  always @(posedge sys_clk_i)
    #1 out_ready_i = rnd_rdy ? 1'($random(seed)) : !stall;

  // ==========================
  // Checking
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    compares++;
    if (seen !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic give_up;
    errors++;
    print_verdict();
  endtask : give_up

  always @(posedge sys_clk_i)
  begin
    if (pix_ready_o === 1'b0)
      saw_full = 1'b1;
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("extra pixel", 32'h1, 32'h0);
      else
        check("pixel", po, exp_q.pop_front());
    end
  end

  function automatic logic [11:0] gain_px(input logic [11:0] dat, off, g);
    logic [12:0] s;
    logic [22:0] p;
    s = {1'b0, dat} + {1'b0, off};
    if (s > 13'hfff)
      s = 13'hfff;
    p = (23'(s[11:0]) * (23'h100 + ((g > 12'h1ff) ? 23'h1ff : 23'(g)))) >> 8;
    return (p > 23'hfff) ? 12'hfff : p[11:0];
  endfunction : gain_px

  function automatic logic [11:0] pg(input logic [1:0] c);
    if (!feat_on || c[0])
      return 12'h000;
    if (c == 2'h0)
      return abs_on ? abs_vr_gain_i : vr;
    return abs_on ? abs_ub_gain_i : ub;
  endfunction : pg

  // ==========================
  // Register and pixel tasks
  task automatic wr(input logic [31:0] a, input logic [31:0] dat);
    reg_addr_i  = a;
    reg_wdata_i = dat;
    reg_wr_i    = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_wr_i = 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] dout);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_rd_i = 1'b0;
    dout     = (reg_rvalid_o === 1'b1) ? reg_rdata_o : 32'hxxxxxxxx;
    @(posedge sys_clk_i);
    #1;
  endtask : rd

  task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
    rd(a, rv);
    check(nm, rv, e);
  endtask : rc

  task automatic px(input logic sof, input logic [1:0] c, input logic [11:0] dat, g);
    pix_sof_i   = sof;
    pix_chan_i  = c;
    pix_data_i  = dat;
    pix_valid_i = 1'b1;
    exp_q.push_back({sof, c, gain_px(dat, pix_offset_i, g)});
    for (int n = 0; pix_ready_o !== 1'b1; n++)
    begin
      if (n > 300)
        give_up();
      @(posedge sys_clk_i);
      #1;
    end
    @(posedge sys_clk_i);
    #1;
  endtask : px

  // Staged gains apply from the frame start on
  task automatic cpx(input logic sof, input logic [1:0] c, input logic [11:0] dat);
    px(sof, c, dat, sof ? stg[c] : act[c]);
    if (sof)
      act = stg;
  endtask : cpx

  task automatic drain;
    pix_valid_i = 1'b0;
    for (int n = 0; exp_q.size() > 0; n++)
    begin
      if (n > 300)
        give_up();
      @(posedge sys_clk_i);
      #1;
    end
  endtask : drain

  // ==========================
  // Sequence
  initial
  begin
    {reg_wr_i, reg_rd_i, complement_mode_i, pix_valid_i, pix_sof_i, rnd_rdy, stall} = '0;
    {reg_addr_i, reg_wdata_i, abs_ub_gain_i, abs_vr_gain_i, pix_offset_i, pix_data_i} = '0;
    {pix_chan_i, ub, vr, abs_on, saw_full} = '0;
    act = '{4{12'h000}};
    seed = 829;
    errors = 0;
    compares = 0;
    feat_on = 1'b1;
    srst_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    rc("ctrl reset", `WBGC_ADDR_CTRL, 32'h00000041);
    rc("inquiry", `WBGC_ADDR_INQ, 32'h00000000);
    rc("pair_a reset", `WBGC_ADDR_PAIR_A, 32'h00000041);
    rc("pair_b reset", `WBGC_ADDR_PAIR_B, 32'h00000001);
    rc("unmapped", 32'hf0f00810, 32'h00000000);
    wr(`WBGC_ADDR_CTRL, 32'habc12342);
    rc("ctrl manual", `WBGC_ADDR_CTRL, 32'habc12343);
    wr(`WBGC_ADDR_CTRL, 32'h555666c0);
    rc("ctrl auto", `WBGC_ADDR_CTRL, 32'habc123c1);
    wr(`WBGC_ADDR_CTRL, 32'h00000000);
    rc("ctrl off", `WBGC_ADDR_CTRL, 32'h00000001);
    $display("test registers done");
    for (k = 0; k < 4; k++)
    begin
      {vr, ub} = 24'($random(seed));
      {abs_vr_gain_i, abs_ub_gain_i} = 24'($random(seed));
      pix_offset_i = 12'($random(seed)) & 12'h0ff;
      feat_on = (k != 1);
      abs_on = (k == 2);
      rnd_rdy = (k == 3);
      wr(`WBGC_ADDR_CTRL, {vr, ub, 1'b0, feat_on, 4'h0, abs_on, 1'b0});
      for (i = 0; i < 16; i++)
        px(i == 0, 2'(i), 12'($random(seed)), pg(2'(i)));
      drain();
    end
    rnd_rdy = 1'b0;
    $display("test primary gain done");
    stall = 1'b1;
    saw_full = 1'b0;
    fork
      begin
        repeat (40) @(posedge sys_clk_i);
        stall = 1'b0;
      end
    join_none
    for (i = 0; i < 6; i++)
      px(1'b0, 2'h0, 12'($random(seed)), pg(2'h0));
    drain();
    check("buffer full", {31'h0, saw_full}, 32'h1);
    $display("test stall done");
    complement_mode_i = 1'b1;
    for (k = 0; k < 3; k++)
    begin
      {stg[0], stg[1]} = 24'($random(seed));
      {stg[2], stg[3]} = 24'($random(seed));
      wr(`WBGC_ADDR_PAIR_A, {stg[0], stg[1], k[0], 7'h40});
      wr(`WBGC_ADDR_PAIR_B, {stg[2], stg[3], 8'h00});
      rc("pair_a", `WBGC_ADDR_PAIR_A, {stg[0], stg[1], k[0], 7'h41});
      rc("pair_b", `WBGC_ADDR_PAIR_B, {stg[2], stg[3], 8'h01});
      for (i = 0; i < 10; i++)
        cpx(i == 3, 2'(i), 12'($random(seed)));
      drain();
    end
    complement_mode_i = 1'b0;
    $display("test four gains done");
    pix_offset_i = 12'h000;
    {vr, ub} = 24'h000000;
    wr(`WBGC_ADDR_CTRL, 32'h00000040);
    wr(`WBGC_ADDR_CTRL, 32'h00000060);
    rc("busy", `WBGC_ADDR_CTRL, 32'h00000061);
    for (k = 0; k < 9; k++)
      for (i = 0; i < 3; i++)
        px(i == 0, 2'(i), (i == 0) ? 12'h080 : 12'h100, pg(2'(i)));
    drain();
    for (i = 0; i < 100; i++)
    begin
      rd(`WBGC_ADDR_CTRL, rv);
      if (rv[5] === 1'b0)
        break;
    end
    check("run result", rv, 32'h10000041);
    vr = 12'h100;
    for (i = 0; i < 6; i++)
      px(i == 0 || i == 3, 2'(i), 12'h200, pg(2'(i)));
    drain();
    rc("run hold", `WBGC_ADDR_CTRL, 32'h10000041);
    $display("test one push done");
    wr(`WBGC_ADDR_CTRL, 32'h000000c0);
    px(1'b1, 2'h0, 12'h100, pg(2'h0));
    px(1'b0, 2'h1, 12'h100, pg(2'h1));
    px(1'b0, 2'h2, 12'h080, pg(2'h2));
    px(1'b1, 2'h1, 12'h100, pg(2'h1));
    drain();
    repeat (30) @(posedge sys_clk_i);
    #1;
    rc("auto result", `WBGC_ADDR_CTRL, 32'h000100c1);
    $display("test auto done");
    print_verdict();
  end
endmodule : testbench
